// file: sdsio_bank.sv
// parameter bank: wait times, dead band, soft inputs, status mirrors
// assumes synchronous single-cycle parameter access from the fieldbus side
`timescale 1ns/100ps
module sdsio_bank #(
    parameter int CYC_PER_MS = sdsio_pkg::CYC_PER_MS,
    parameter int ERR_W = 32
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_addr,
    input wire logic [15:0] par_wdata,
    output logic [15:0] par_rdata,
    output logic par_ack,
    output logic par_err,
    input wire logic [15:0] conn_in_a,
    input wire logic [15:0] conn_in_b,
    output logic [15:0] func_in_a,
    output logic [15:0] func_in_b,
    input wire logic [15:0] drive_status_a,
    input wire logic [15:0] drive_status_b,
    input wire logic [2:0] gain_mode,
    output logic gain_set_two,
    input wire logic signed [ERR_W-1:0] position_error,
    input wire logic signed [ERR_W-1:0] position_ctrl_raw,
    output logic signed [ERR_W-1:0] position_ctrl_out,
    output logic in1_polarity,
    output logic [7:0] in1_function
);
    if (CYC_PER_MS < 1 || ERR_W < 17) begin : g_bad_param
        $error("sdsio_bank: bad parameter");
    end

    logic [15:0] up_wait_q, up_wait_d, down_wait_q, down_wait_d;
    logic [15:0] band_q, band_d, soft_a_q, soft_a_d, soft_b_q, soft_b_d;
    logic [15:0] func_q, func_d, rdata_q, rdata_d;
    logic ack_q, ack_d, err_q, err_d;
    logic [15:0] conn_a_s1_q, conn_a_q, conn_b_s1_q, conn_b_q;
    logic [15:0] stat_a_s1_q, stat_a_q, stat_b_s1_q, stat_b_q;

    // register access
    always_comb begin
        up_wait_d = up_wait_q;
        down_wait_d = down_wait_q;
        band_d = band_q;
        soft_a_d = soft_a_q;
        soft_b_d = soft_b_q;
        func_d = func_q;
        rdata_d = rdata_q;
        ack_d = par_wr | par_rd;
        err_d = 1'b0;
        if (par_wr) begin
            case (par_addr)
                sdsio_pkg::ADDR_GAIN_UP_WAIT:
                    up_wait_d = par_wdata;
                sdsio_pkg::ADDR_GAIN_DOWN_WAIT:
                    down_wait_d = par_wdata;
                sdsio_pkg::ADDR_DEAD_BAND: band_d = par_wdata;
                sdsio_pkg::ADDR_SOFT_IN_A: soft_a_d = par_wdata;
                sdsio_pkg::ADDR_SOFT_IN_B: soft_b_d = par_wdata;
                sdsio_pkg::ADDR_IN1_FUNC: func_d = par_wdata;
                sdsio_pkg::ADDR_STATUS_A, sdsio_pkg::ADDR_STATUS_B:
                    err_d = 1'b1;
                default: err_d = 1'b1;
            endcase
        end else if (par_rd) begin
            case (par_addr)
                sdsio_pkg::ADDR_GAIN_UP_WAIT: rdata_d = up_wait_q;
                sdsio_pkg::ADDR_GAIN_DOWN_WAIT: rdata_d = down_wait_q;
                sdsio_pkg::ADDR_DEAD_BAND: rdata_d = band_q;
                sdsio_pkg::ADDR_SOFT_IN_A: rdata_d = soft_a_q;
                sdsio_pkg::ADDR_SOFT_IN_B: rdata_d = soft_b_q;
                sdsio_pkg::ADDR_STATUS_A:
                    rdata_d = stat_a_q & sdsio_pkg::STATUS_A_VALID;
                sdsio_pkg::ADDR_STATUS_B:
                    rdata_d = stat_b_q & sdsio_pkg::STATUS_B_VALID;
                sdsio_pkg::ADDR_IN1_FUNC: rdata_d = func_q;
                default: begin
                    rdata_d = 16'h0000;
                    err_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            up_wait_q <= sdsio_pkg::RST_WAIT;
            down_wait_q <= sdsio_pkg::RST_WAIT;
            band_q <= sdsio_pkg::RST_DEAD_BAND;
            soft_a_q <= sdsio_pkg::RST_SOFT_IN;
            soft_b_q <= sdsio_pkg::RST_SOFT_IN;
            func_q <= sdsio_pkg::RST_IN1_FUNC;
            rdata_q <= 16'h0000;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            conn_a_s1_q <= 16'h0000;
            conn_a_q <= 16'h0000;
            conn_b_s1_q <= 16'h0000;
            conn_b_q <= 16'h0000;
            stat_a_s1_q <= 16'h0000;
            stat_a_q <= 16'h0000;
            stat_b_s1_q <= 16'h0000;
            stat_b_q <= 16'h0000;
        end else begin
            up_wait_q <= up_wait_d;
            down_wait_q <= down_wait_d;
            band_q <= band_d;
            soft_a_q <= soft_a_d;
            soft_b_q <= soft_b_d;
            func_q <= func_d;
            rdata_q <= rdata_d;
            ack_q <= ack_d;
            err_q <= err_d;
            conn_a_s1_q <= conn_in_a;
            conn_a_q <= conn_a_s1_q;
            conn_b_s1_q <= conn_in_b;
            conn_b_q <= conn_b_s1_q;
            stat_a_s1_q <= drive_status_a;
            stat_a_q <= stat_a_s1_q;
            stat_b_s1_q <= drive_status_b;
            stat_b_q <= stat_b_s1_q;
        end
    end

    assign par_rdata = rdata_q;
    assign par_ack = ack_q;
    assign par_err = err_q;
    assign in1_polarity = func_q[sdsio_pkg::FUNC_POL_BIT];
    assign in1_function = func_q[sdsio_pkg::FUNC_SEL_MSB:0];

    // input functions, registered
    logic [15:0] fin_a_q, fin_a_d, fin_b_q, fin_b_d;
    always_comb begin
        fin_a_d = (conn_a_q | soft_a_q) & sdsio_pkg::SOFT_A_VALID;
        fin_b_d = conn_b_q | soft_b_q;
    end
    assign func_in_a = fin_a_q;
    assign func_in_b = fin_b_q;

    // gain set switching with separate waits
    typedef enum logic [1:0] {SDSIO_SET1, SDSIO_WAIT_UP, SDSIO_SET2,
        SDSIO_WAIT_DOWN} sdsio_gain_t;
    sdsio_gain_t gst_q, gst_d;
    logic [15:0] ms_q, ms_d;
    logic [31:0] cyc_q, cyc_d;
    logic want_two;
    logic tick;
    always_comb begin
        want_two = (gain_mode == sdsio_pkg::GAIN_MODE_INPUT) &&
            fin_a_q[sdsio_pkg::SOFT_A_GAIN_SET_TWO_SELECT_BIT];
        tick = (cyc_q == 32'(CYC_PER_MS - 1));
        gst_d = gst_q;
        ms_d = ms_q;
        cyc_d = tick ? 32'h0 : cyc_q + 32'h1;
        case (gst_q)
            SDSIO_SET1: begin
                cyc_d = 32'h0;
                ms_d = 16'h0;
                if (want_two) begin
                    gst_d = (up_wait_q == 16'h0) ? SDSIO_SET2 : SDSIO_WAIT_UP;
                end
            end
            SDSIO_WAIT_UP: begin
                if (!want_two) begin
                    gst_d = SDSIO_SET1;
                end else if (tick) begin
                    ms_d = ms_q + 16'h1;
                    if (ms_q + 16'h1 >= up_wait_q) begin
                        gst_d = SDSIO_SET2;
                    end
                end
            end
            SDSIO_SET2: begin
                cyc_d = 32'h0;
                ms_d = 16'h0;
                if (!want_two) begin
                    gst_d = (down_wait_q == 16'h0) ? SDSIO_SET1 :
                        SDSIO_WAIT_DOWN;
                end
            end
            SDSIO_WAIT_DOWN: begin
                if (want_two) begin
                    gst_d = SDSIO_SET2;
                end else if (tick) begin
                    ms_d = ms_q + 16'h1;
                    if (ms_q + 16'h1 >= down_wait_q) begin
                        gst_d = SDSIO_SET1;
                    end
                end
            end
            default: gst_d = SDSIO_SET1;
        endcase
    end

    // dead band on position controller output
    logic signed [ERR_W-1:0] pout_q, pout_d;
    logic [ERR_W-1:0] err_mag;
    always_comb begin
        err_mag = position_error[ERR_W-1] ? ERR_W'(-position_error) :
            ERR_W'(position_error);
        pout_d = (err_mag < ERR_W'(band_q)) ? '0 : position_ctrl_raw;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            fin_a_q <= 16'h0000;
            fin_b_q <= 16'h0000;
            gst_q <= SDSIO_SET1;
            ms_q <= 16'h0000;
            cyc_q <= 32'h0;
            pout_q <= '0;
        end else begin
            fin_a_q <= fin_a_d;
            fin_b_q <= fin_b_d;
            gst_q <= gst_d;
            ms_q <= ms_d;
            cyc_q <= cyc_d;
            pout_q <= pout_d;
        end
    end
    assign gain_set_two = (gst_q == SDSIO_SET2) || (gst_q == SDSIO_WAIT_DOWN);
    assign position_ctrl_out = pout_q;

    a_soft_or_a: assert property (@(posedge clock) disable iff (!nrst)
        fin_a_q == (($past(conn_a_q) | $past(soft_a_q)) &
        sdsio_pkg::SOFT_A_VALID))
        else $error("soft input A mismatch");
    a_soft_or_b: assert property (@(posedge clock) disable iff (!nrst)
        fin_b_q == ($past(conn_b_q) | $past(soft_b_q)))
        else $error("soft input B mismatch");
    a_reserved_nine: assert property (@(posedge clock) disable iff (!nrst)
        !func_in_a[9]) else $error("reserved bit 9 drives");
    a_status_a_mask: assert property (@(posedge clock) disable iff (!nrst)
        $past(par_rd) && !$past(par_wr) &&
        $past(par_addr) == sdsio_pkg::ADDR_STATUS_A |->
        par_rdata[15:11] == 5'h00) else $error("status A reserved");
    a_status_b_mask: assert property (@(posedge clock) disable iff (!nrst)
        $past(par_rd) && !$past(par_wr) &&
        $past(par_addr) == sdsio_pkg::ADDR_STATUS_B |->
        par_rdata[15:8] == 8'h00) else $error("status B reserved");
    a_soft_write: assert property (@(posedge clock) disable iff (!nrst)
        par_wr && par_addr == sdsio_pkg::ADDR_SOFT_IN_A |=>
        soft_a_q == $past(par_wdata))
        else $error("soft word A not written");
    a_dead_band: assert property (@(posedge clock) disable iff (!nrst)
        err_mag < ERR_W'(band_q) |=> position_ctrl_out == '0)
        else $error("dead band not applied");
    a_gain_up_zero: assert property (@(posedge clock) disable iff (!nrst)
        gst_q == SDSIO_SET1 && want_two && up_wait_q == 16'h0 |=>
        gain_set_two) else $error("zero up wait not immediate");
    a_gain_mode_off: assert property (@(posedge clock) disable iff (!nrst)
        gain_mode != sdsio_pkg::GAIN_MODE_INPUT && gst_q == SDSIO_SET2 &&
        down_wait_q == 16'h0
        |=> !gain_set_two) else $error("gain two held");
    a_wait_down_hold: assert property (@(posedge clock) disable iff (!nrst)
        gst_q == SDSIO_WAIT_DOWN |-> gain_set_two)
        else $error("left set two early");
    c_gain_up: cover property (@(posedge clock) gst_q == SDSIO_WAIT_UP
        ##1 gst_q == SDSIO_SET2);
    c_gain_down: cover property (@(posedge clock) gst_q == SDSIO_WAIT_DOWN
        ##1 gst_q == SDSIO_SET1);
    c_band_zero: cover property (@(posedge clock) band_q != 16'h0 &&
        err_mag < ERR_W'(band_q));
endmodule : sdsio_bank

// file: sdsio_field_model.sv
// fieldbus master model: one-cycle parameter read and write pulses
// assumes the bank answers with par_ack one edge after the request
`timescale 1ns/100ps
module sdsio_field_model (
    input wire logic clock,
    output logic par_wr,
    output logic par_rd,
    output logic [15:0] par_addr,
    output logic [15:0] par_wdata,
    input wire logic [15:0] par_rdata,
    input wire logic par_ack,
    input wire logic par_err
);
    initial begin
        par_wr = 1'b0;
        par_rd = 1'b0;
        par_addr = 16'h0000;
        par_wdata = 16'h0000;
    end
    // released address and data lines show the inverse of their last value
    task automatic access(input logic wr, input logic [15:0] a,
        input logic [15:0] d, output logic [15:0] q, output logic [1:0] ae);
        @(posedge clock);
        par_wr <= wr;
        par_rd <= ~wr;
        par_addr <= a;
        par_wdata <= d;
        @(posedge clock);
        par_wr <= 1'b0;
        par_rd <= 1'b0;
        par_addr <= ~a;
        par_wdata <= ~d;
        // answer is sampled at the edge after the request was taken
        @(posedge clock);
        q = par_rdata;
        ae = {par_ack, par_err};
    endtask : access
endmodule : sdsio_field_model

// file: sdsio_pkg.sv
// constants, register map and field layout of the soft i/o parameter bank
// assumes one 125 MHz control clock and an object-dictionary access port
// Functional notes
// - returning from gain set two to gain set one uses its own wait time.
// - moving from gain set one to two waits a programmable 0..1000 ms, default 0; the bank takes any 16-bit value without par_err and waits up to 65535 ms.
// - moving from gain set two back to one waits a separate 0..1000 ms, default 0; the bank takes any 16-bit value without par_err and waits up to 65535 ms.
// - position controller output is zero while position error is below dead band.
// - every input function is the OR of its connector input and its soft bit.
// - soft word A maps limits, homing, stop, p-control, gain two, torque limits, mode, bit 9 reserved, then e-stop, alarm reset, servo enable, speed selects.
// - soft word B maps start, pause, registration, homing start, index selects, absolute request, jog, clear, override, inhibit.
// - both soft words are read-write, reset to zero and writable at any time.
// - status word A mirrors eleven drive outputs on bits 10..0, upper bits zero.
// - status word B mirrors origin, end of sequence and six index outputs on bits 7..0.
// - input one function word is read-write with initial value 0x000F.
// - input function word bit 15 is contact polarity, bits 7..0 the function.
// - with gain mode 2 the gain-two input selects gain set two.
package sdsio_pkg;
    localparam logic [15:0] ADDR_GAIN_UP_WAIT = 16'h211C;
    localparam logic [15:0] ADDR_GAIN_DOWN_WAIT = 16'h211D;
    localparam logic [15:0] ADDR_DEAD_BAND = 16'h211E;
    localparam logic [15:0] ADDR_SOFT_IN_A = 16'h211F;
    localparam logic [15:0] ADDR_SOFT_IN_B = 16'h2120;
    localparam logic [15:0] ADDR_STATUS_A = 16'h2121;
    localparam logic [15:0] ADDR_STATUS_B = 16'h2122;
    localparam logic [15:0] ADDR_IN1_FUNC = 16'h2200;
    localparam logic [15:0] RST_WAIT = 16'h0000;
    localparam logic [15:0] RST_DEAD_BAND = 16'h0000;
    localparam logic [15:0] RST_SOFT_IN = 16'h0000;
    localparam logic [15:0] RST_IN1_FUNC = 16'h000F;
    localparam logic [15:0] MAX_WAIT_MS = 16'h03E8;
    localparam logic [15:0] MAX_DEAD_BAND = 16'h03E8;
    localparam logic [15:0] SOFT_A_VALID = 16'hFDFF;
    localparam logic [15:0] STATUS_A_VALID = 16'h07FF;
    localparam logic [15:0] STATUS_B_VALID = 16'h00FF;
    localparam int SOFT_A_GAIN_SET_TWO_SELECT_BIT = 5;
    localparam int FUNC_POL_BIT = 15;
    localparam int FUNC_SEL_MSB = 7;
    localparam logic [2:0] GAIN_MODE_INPUT = 3'h2;
    localparam int CLK_MHZ = 125;
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 8;
    localparam int CYC_PER_MS = MS_NS / CLK_NS;
endpackage : sdsio_pkg

// file: servo_drive_soft_io_params_tb.sv
// bench of the soft i/o bank: registers, or-merge, dead band, gain wait
// assumes sdsio_field_model issues every parameter access
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin \
    num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
    end end
module servo_drive_soft_io_params_tb;
    logic clock, nrst, par_wr, par_rd, par_ack, par_err, gain_set_two;
    logic [15:0] par_addr, par_wdata, par_rdata, conn_in_a, conn_in_b;
    logic [15:0] func_in_a, func_in_b, drive_status_a, drive_status_b;
    logic [2:0] gain_mode;
    logic signed [31:0] position_error, position_ctrl_raw, position_ctrl_out;
    logic in1_polarity;
    logic [7:0] in1_function;
    int num_errors = 0;
    int n_tests = 0;
    logic [15:0] adr [8] = '{16'h211C, 16'h211D, 16'h211E, 16'h211F,
        16'h2120, 16'h2121, 16'h2122, 16'h2200};
    sdsio_bank #(.CYC_PER_MS(4), .ERR_W(32)) u_sdsio_bank (.clock, .nrst,
        .par_wr, .par_rd, .par_addr, .par_wdata, .par_rdata, .par_ack,
        .par_err, .conn_in_a, .conn_in_b, .func_in_a, .func_in_b,
        .drive_status_a, .drive_status_b, .gain_mode, .gain_set_two,
        .position_error, .position_ctrl_raw, .position_ctrl_out,
        .in1_polarity, .in1_function);
    sdsio_field_model u_sdsio_field_model (.clock, .par_wr, .par_rd,
        .par_addr, .par_wdata, .par_rdata, .par_ack, .par_err);
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        stop_test();
    end
    task automatic wr(input logic [15:0] a, d, input logic [1:0] eae);
        logic [15:0] q;
        logic [1:0] ae;
        u_sdsio_field_model.access(1'b1, a, d, q, ae);
        `CHK("write ack err", eae, ae)
    endtask : wr
    task automatic rd(input logic [15:0] a, ex, input logic [1:0] eae);
        logic [15:0] q;
        logic [1:0] ae;
        u_sdsio_field_model.access(1'b0, a, 16'h0000, q, ae);
        `CHK("read ack err", eae, ae)
        `CHK("read data", ex, q)
    endtask : rd
    task automatic t_regs();
        for (int i = 0; i < 8; i++) begin
            rd(adr[i], (i == 7) ? 16'h000F : 16'h0000, 2'b10);
        end
        for (int i = 0; i < 5; i++) begin
            wr(adr[i], 16'(16'h03E8 - i), 2'b10);
            rd(adr[i], 16'(16'h03E8 - i), 2'b10);
        end
        wr(16'h2121, 16'hFFFF, 2'b11);
        rd(16'h2121, 16'h0000, 2'b10);
        rd(16'h3000, 16'h0000, 2'b11);
        wr(16'h2200, 16'h8006, 2'b10);
        rd(16'h2200, 16'h8006, 2'b10);
        `CHK("polarity", 1'b1, in1_polarity)
        `CHK("function", 8'h06, in1_function)
        $display("test registers done");
    endtask : t_regs
    task automatic t_or();
        wr(16'h211F, 16'h0000, 2'b10);
        wr(16'h2120, 16'hA5A5, 2'b10);
        conn_in_a <= 16'h0001;
        conn_in_b <= 16'h5A5A;
        repeat (5) @(posedge clock);
        `CHK("conn only a", 16'h0001, func_in_a)
        `CHK("or b", 16'hFFFF, func_in_b)
        conn_in_a <= 16'h0000;
        wr(16'h211F, 16'hFFFF, 2'b10);
        repeat (5) @(posedge clock);
        `CHK("soft a", 16'hFDFF, func_in_a)
        wr(16'h211F, 16'h0000, 2'b10);
        $display("test or-merge done");
    endtask : t_or
    task automatic t_status();
        drive_status_a <= 16'hF555;
        drive_status_b <= 16'hFF5A;
        repeat (4) @(posedge clock);
        rd(16'h2121, 16'h0555, 2'b10);
        rd(16'h2122, 16'h005A, 2'b10);
        $display("test status done");
    endtask : t_status
    task automatic t_dead();
        int ev [4] = '{9, -9, 10, -10};
        wr(16'h211E, 16'h000A, 2'b10);
        position_ctrl_raw <= 32'sh1234;
        for (int i = 0; i < 4; i++) begin
            position_error <= ev[i];
            repeat (3) @(posedge clock);
            `CHK("ctrl", (i < 2) ? 32'sh0 : 32'sh1234, position_ctrl_out)
        end
        $display("test dead band done");
    endtask : t_dead
    task automatic t_wait(input logic lvl, input int lo, hi);
        int n = 0;
        while (gain_set_two !== lvl && n < 40) begin
            @(posedge clock);
            #1;
            n++;
        end
        `CHK("gain delay in range", 1'b1, n >= lo && n <= hi)
    endtask : t_wait
    task automatic t_gain();
        gain_mode <= 3'h2;
        wr(16'h211C, 16'h0003, 2'b10);
        wr(16'h211D, 16'h0001, 2'b10);
        wr(16'h211F, 16'h0020, 2'b10);
        t_wait(1'b1, 12, 16);
        wr(16'h211F, 16'h0000, 2'b10);
        t_wait(1'b0, 4, 8);
        wr(16'h211D, 16'h0008, 2'b10);
        wr(16'h211F, 16'h0020, 2'b10);
        repeat (5) @(posedge clock);
        wr(16'h211F, 16'h0000, 2'b10);
        repeat (16) @(posedge clock);
        `CHK("aborted rise", 1'b0, gain_set_two)
        wr(16'h211C, 16'h0000, 2'b10);
        wr(16'h211D, 16'h0000, 2'b10);
        wr(16'h211F, 16'h0020, 2'b10);
        t_wait(1'b1, 0, 3);
        wr(16'h211F, 16'h0000, 2'b10);
        t_wait(1'b0, 0, 3);
        wr(16'h211F, 16'h0020, 2'b10);
        t_wait(1'b1, 0, 3);
        gain_mode <= 3'h0;
        repeat (3) @(posedge clock);
        `CHK("mode off", 1'b0, gain_set_two)
        $display("test gain wait done");
    endtask : t_gain
    initial begin
        nrst = 1'b0;
        conn_in_a = 16'h0000;
        conn_in_b = 16'h0000;
        drive_status_a = 16'h0000;
        drive_status_b = 16'h0000;
        gain_mode = 3'h0;
        position_error = 32'sh0;
        position_ctrl_raw = 32'sh0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_or();
        t_status();
        t_dead();
        t_gain();
        stop_test();
    end
endmodule : servo_drive_soft_io_params_tb
